// >>> interval_counter_regs.svh
// timing counts, field positions and reset values of the counter bank
// assumes the includer supplies nothing; definitions only
`ifndef INTERVAL_COUNTER_REGS_SVH
`define INTERVAL_COUNTER_REGS_SVH

// system clock and on-board reference, in ns
`define CLK_PERIOD_NS 4
`define REF_PERIOD_NS 100
`define REF_DIV (`REF_PERIOD_NS / `CLK_PERIOD_NS)
`define REF_HALF (`REF_DIV / 2)

// bank shape
`define NUM_GROUPS 5
`define PER_GROUP 3
`define NUM_CTRS 15

// mode control byte fields
`define CTRL_IDX_HI 7
`define CTRL_IDX_LO 6
`define CTRL_ACC_HI 5
`define CTRL_ACC_LO 4
`define CTRL_MODE_HI 3
`define CTRL_MODE_LO 1
`define CTRL_BCD 0

// reset values
`define COUNT_RST 16'h0000
`define MODE_RST 3'h0

`endif

// >>> interval_counter_pkg.sv
// types shared by the counter bank and its users
// assumes the constants header for widths and positions
package interval_counter_pkg;

  // host command kinds
  typedef enum logic [1:0] {
    CMD_MODE = 2'b00,
    CMD_LOAD = 2'b01,
    CMD_MODE_LOAD = 2'b10,
    CMD_READ = 2'b11
  } cmd_kind_type;

  // counter operating modes
  typedef enum logic [2:0] {
    MODE_TC_PULSE = 3'b000,
    MODE_ONE_SHOT = 3'b001,
    MODE_RATE = 3'b010,
    MODE_SQUARE = 3'b011,
    MODE_SW_STROBE = 3'b100,
    MODE_HW_STROBE = 3'b101
  } mode_type;

  // one host command
  typedef struct packed {
    cmd_kind_type kind;
    logic [2:0] group;
    logic [7:0] ctrl;
    logic [15:0] load;
  } cmd_type;

  // one read answer
  typedef struct packed {
    logic [3:0] index;
    logic [15:0] count;
  } rd_type;

endpackage : interval_counter_pkg

// >>> interval_counter_bank.sv
// bank of fifteen 16-bit down-counters with a host command port
// assumes a 250 MHz clk_i; field clocks and gates are asynchronous pins
`include "interval_counter_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module interval_counter_bank (
  // clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // host command port
  input wire logic cmd_valid_i,
  input var interval_counter_pkg::cmd_type cmd_i,
  output logic rd_valid_o,
  output var interval_counter_pkg::rd_type rd_o,
  // field pins
  input wire logic [`NUM_CTRS-1:0] ctr_clk_i,
  input wire logic [`NUM_CTRS-1:0] ctr_gate_i,
  input wire logic [`NUM_CTRS-1:0] ctr_src_ref_i,
  output logic [`NUM_CTRS-1:0] ctr_out_o,
  // on-board reference
  output logic ref_clk_o
);

  // flat counter index from group and byte index; 4'hf when invalid
  function automatic logic [3:0] ctr_index(input logic [2:0] grp,
                                           input logic [1:0] sub);
    if (grp < 3'(`NUM_GROUPS) && sub < 2'(`PER_GROUP)) begin
      // widen before the product: group 4 times 3 needs four bits
      ctr_index = 4'(grp) * 4'(`PER_GROUP) + 4'(sub);
    end else begin
      ctr_index = 4'hf;
    end
  endfunction : ctr_index

  // decoded command
  logic [3:0] cmd_idx;
  logic cmd_ok;
  logic [2:0] cmd_mode;
  logic do_mode;
  logic do_load;
  assign cmd_idx = ctr_index(cmd_i.group,
    cmd_i.ctrl[`CTRL_IDX_HI:`CTRL_IDX_LO]);
  assign cmd_mode = cmd_i.ctrl[`CTRL_MODE_HI:`CTRL_MODE_LO];
  // layout check
  // a half-width access or bcd bit is refused: the bank is 16-bit only
  assign cmd_ok = cmd_valid_i && ce_i && cmd_idx != 4'hf &&
    cmd_i.ctrl[`CTRL_ACC_HI:`CTRL_ACC_LO] == 2'b11 &&
    !cmd_i.ctrl[`CTRL_BCD] && cmd_mode <= 3'h5;
  assign do_mode = cmd_ok && (cmd_i.kind == interval_counter_pkg::CMD_MODE
    || cmd_i.kind == interval_counter_pkg::CMD_MODE_LOAD);
  // full load
  // the load always carries both bytes in one command
  assign do_load = cmd_ok && (cmd_i.kind == interval_counter_pkg::CMD_LOAD
    || cmd_i.kind == interval_counter_pkg::CMD_MODE_LOAD);

  // reference divider state
  logic [4:0] ref_cnt_q;
  logic ref_clk_q;
  logic ref_tick_q; // one-cycle pulse on each reference falling edge

  // reference divider
  // 250 MHz divided by 25 gives the 10 MHz counting source
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      ref_cnt_q <= 5'h00;
      ref_clk_q <= 1'b0;
      ref_tick_q <= 1'b0;
    end else if (ce_i) begin
      if (ref_cnt_q == 5'(`REF_DIV - 1)) begin
        ref_cnt_q <= 5'h00;
      end else begin
        ref_cnt_q <= ref_cnt_q + 5'h01;
      end
      // high for the first half of the period
      ref_clk_q <= ref_cnt_q < 5'(`REF_HALF);
      ref_tick_q <= ref_cnt_q == 5'(`REF_HALF);
    end
  end
  assign ref_clk_o = ref_clk_q;

  // per-counter state
  logic [15:0] count_q [`NUM_CTRS];
  logic [15:0] init_q [`NUM_CTRS];
  logic [2:0] mode_q [`NUM_CTRS];
  logic [`NUM_CTRS-1:0] out_q;
  logic [`NUM_CTRS-1:0] run_q;    // counting enabled
  logic [`NUM_CTRS-1:0] pend_q;   // trigger seen, load on next tick
  logic [`NUM_CTRS-1:0] strobe_q; // strobe low, release on next tick
  logic [`NUM_CTRS-1:0] gate_lvl; // filtered gate level

  genvar g;
  generate
    for (g = 0; g < `NUM_CTRS; g++) begin : ctr
      // three-stage synchronisers and filtered levels
      logic [2:0] csync_q;
      logic [2:0] gsync_q;
      logic cstab_q;
      logic gstab_q;
      logic fall;
      logic trig;
      logic tick;
      logic sel;
      logic last;
      logic [15:0] half;

      // pin synchronisers
      // a change counts only once stages two and three agree
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          csync_q <= 3'h7;
          gsync_q <= 3'h7;
          cstab_q <= 1'b1;
          gstab_q <= 1'b1;
        end else if (ce_i) begin
          csync_q <= {csync_q[1:0], ctr_clk_i[g]};
          gsync_q <= {gsync_q[1:0], ctr_gate_i[g]};
          if (csync_q[2] == csync_q[1]) begin
            cstab_q <= csync_q[2];
          end
          if (gsync_q[2] == gsync_q[1]) begin
            gstab_q <= gsync_q[2];
          end
        end
      end

      assign fall = cstab_q && !csync_q[1] && !csync_q[2];
      assign trig = !gstab_q && gsync_q[1] && gsync_q[2];
      assign gate_lvl[g] = gstab_q;
      assign sel = ctr_src_ref_i[g];
      assign tick = ce_i && (sel ? ref_tick_q : fall);
      // zero load wraps to 65535 first, so it spans 65536 counts
      assign last = count_q[g] == 16'h0001;
      // odd count gets the extra count in the high half
      assign half = out_q[g] ? init_q[g] + 16'(init_q[g][0])
                             : init_q[g] - 16'(init_q[g][0]);

      // mode and load value held from host commands
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          mode_q[g] <= `MODE_RST;
          init_q[g] <= `COUNT_RST;
        end else begin
          if (do_mode && cmd_idx == 4'(g)) begin
            mode_q[g] <= cmd_mode;
          end
          if (do_load && cmd_idx == 4'(g)) begin
            init_q[g] <= cmd_i.load;
          end
        end
      end

      // counting engine: commands first, then triggers, then ticks
      always_ff @(posedge clk_i) begin
        if (reset_i) begin
          count_q[g] <= `COUNT_RST;
          out_q[g] <= 1'b0;
          run_q[g] <= 1'b0;
          pend_q[g] <= 1'b0;
          strobe_q[g] <= 1'b0;
        end else if (do_load && cmd_idx == 4'(g)) begin
          // a load restarts the counter in the mode now chosen
          count_q[g] <= cmd_i.load;
          pend_q[g] <= 1'b0;
          strobe_q[g] <= 1'b0;
          case (do_mode ? cmd_mode : mode_q[g])
            3'h0: begin
              out_q[g] <= 1'b0;
              run_q[g] <= 1'b0;
            end
            // trigger-started modes 1 and 5 wait with output high; mode 0 waits low
            3'h1, 3'h5: begin
              out_q[g] <= 1'b1;
              run_q[g] <= 1'b0;
            end
            default: begin
              out_q[g] <= 1'b1;
              run_q[g] <= 1'b1;
            end
          endcase
        end else if (do_mode && cmd_idx == 4'(g)) begin
          // mode only: park the counter, mode 0 parks low
          out_q[g] <= cmd_mode != 3'h0;
          run_q[g] <= 1'b0;
          pend_q[g] <= 1'b0;
          strobe_q[g] <= 1'b0;
        end else if (ce_i) begin
          case (mode_q[g])
            3'h0: begin
              if (trig && !out_q[g]) begin
                run_q[g] <= 1'b1;
              end else if (tick && run_q[g]) begin
                count_q[g] <= count_q[g] - 16'h0001;
                if (last) begin
                  out_q[g] <= 1'b1;
                  run_q[g] <= 1'b0;
                end
              end
            end
            3'h1, 3'h5: begin
              if (trig) begin
                pend_q[g] <= 1'b1;
              end else if (tick && pend_q[g]) begin
                count_q[g] <= init_q[g];
                pend_q[g] <= 1'b0;
                run_q[g] <= 1'b1;
                out_q[g] <= mode_q[g] == 3'h5;
              end else if (tick && strobe_q[g]) begin
                out_q[g] <= 1'b1;
                strobe_q[g] <= 1'b0;
              end else if (tick && run_q[g]) begin
                count_q[g] <= count_q[g] - 16'h0001;
                if (last) begin
                  run_q[g] <= 1'b0;
                  if (mode_q[g] == 3'h5) begin
                    out_q[g] <= 1'b0;
                    strobe_q[g] <= 1'b1;
                  end else begin
                    out_q[g] <= 1'b1;
                  end
                end
              end
            end
            3'h2: begin
              if (trig) begin
                count_q[g] <= init_q[g];
                out_q[g] <= 1'b1;
              end else if (tick && run_q[g] && gate_lvl[g]) begin
                if (last) begin
                  count_q[g] <= init_q[g];
                  out_q[g] <= 1'b1;
                end else begin
                  count_q[g] <= count_q[g] - 16'h0001;
                  out_q[g] <= count_q[g] != 16'h0002;
                end
              end else if (!gate_lvl[g]) begin
                out_q[g] <= 1'b1;
              end
            end
            3'h3: begin
              if (trig) begin
                count_q[g] <= init_q[g] + 16'(init_q[g][0]);
                out_q[g] <= 1'b1;
              end else if (tick && run_q[g] && gate_lvl[g]) begin
                if (count_q[g] == 16'h0002) begin
                  out_q[g] <= !out_q[g];
                  // reload for the opposite half
                  count_q[g] <= out_q[g]
                    ? init_q[g] - 16'(init_q[g][0])
                    : init_q[g] + 16'(init_q[g][0]);
                end else if (count_q[g] == init_q[g] && init_q[g][0]) begin
                  // first tick of an odd run loads the even high half
                  count_q[g] <= half - 16'h0002;
                end else begin
                  count_q[g] <= count_q[g] - 16'h0002;
                end
              end
            end
            3'h4: begin
              if (tick && strobe_q[g]) begin
                out_q[g] <= 1'b1;
                strobe_q[g] <= 1'b0;
              end else if (tick && run_q[g] && gate_lvl[g]) begin
                count_q[g] <= count_q[g] - 16'h0001;
                if (last) begin
                  out_q[g] <= 1'b0;
                  strobe_q[g] <= 1'b1;
                  run_q[g] <= 1'b0;
                end
              end
            end
            default: begin
              run_q[g] <= 1'b0;
            end
          endcase
        end
      end
    end
  endgenerate

  assign ctr_out_o = out_q;

  // read answer
  logic rd_valid_q;
  interval_counter_pkg::rd_type rd_q;

  // read count
  // answer one cycle after the command, with the live count
  always_ff @(posedge clk_i) begin
    if (reset_i) begin
      rd_valid_q <= 1'b0;
      rd_q <= '0;
    end else begin
      rd_valid_q <= cmd_valid_i && ce_i && cmd_idx != 4'hf &&
        cmd_i.kind == interval_counter_pkg::CMD_READ;
      if (cmd_valid_i && ce_i && cmd_idx != 4'hf) begin
        rd_q.index <= cmd_idx;
        rd_q.count <= count_q[cmd_idx];
      end
    end
  end
  assign rd_valid_o = rd_valid_q;
  assign rd_o = rd_q;

endmodule : interval_counter_bank

`default_nettype wire

// >>> interval_counter_bank_assertions.sv
// checker for the counter bank: command port, outputs, reference
// assumes it is bound to interval_counter_bank and sees its ports only
`include "interval_counter_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module interval_counter_bank_chk (
  // clock and control
  input wire logic clk_i,
  input wire logic reset_i,
  input wire logic ce_i,
  // host side
  input wire logic cmd_valid_i,
  input var interval_counter_pkg::cmd_type cmd_i,
  input wire logic rd_valid_o,
  input var interval_counter_pkg::rd_type rd_o,
  // field side
  input wire logic [`NUM_CTRS-1:0] ctr_out_o,
  input wire logic ref_clk_o
);
  // index and validity of the command on offer
  logic [3:0] idx;
  logic ok_idx;
  logic ok_ctl;
  logic take;
  logic is_rd;
  assign idx = 4'(cmd_i.group) * 4'h3 + 4'(cmd_i.ctrl[7:6]);
  assign ok_idx = cmd_i.group <= 3'h4 && cmd_i.ctrl[7:6] != 2'h3;
  assign ok_ctl = cmd_i.ctrl[5:4] == 2'h3 && !cmd_i.ctrl[0]
    && cmd_i.ctrl[3:1] <= 3'h5;
  assign take = cmd_valid_i && ce_i && ok_idx;
  assign is_rd = cmd_i.kind == interval_counter_pkg::CMD_READ;

  // a frozen clock enable stalls everything but rd_valid_o, which clears, so checks pause with it
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i || !ce_i);

  read_answer_a: assert property (take && is_rd |=> rd_valid_o)
    else $error("read not answered");
  no_stray_a: assert property (rd_valid_o |-> $past(take && is_rd))
    else $error("answer without read");
  rd_index_a: assert property (rd_valid_o |-> rd_o.index == $past(idx))
    else $error("answer index wrong");
  // reference 25 cycles, high 12 then low 13
  ref_period_a: assert property (
    $rose(ref_clk_o) |-> ##12 $fell(ref_clk_o) ##13 $rose(ref_clk_o))
    else $error("reference period wrong");
  refuse_a: assert property (
    cmd_valid_i && is_rd && !ok_idx |=> !rd_valid_o)
    else $error("bad index answered");
  m4_load_a: assert property (
    take && ok_ctl && cmd_i.ctrl[3:1] == 3'h4
    && cmd_i.kind == interval_counter_pkg::CMD_MODE_LOAD
    |=> ctr_out_o[$past(idx)])
    else $error("strobe mode output not high");
  m0_load_a: assert property (
    take && ok_ctl && cmd_i.ctrl[3:1] == 3'h0
    && cmd_i.kind == interval_counter_pkg::CMD_MODE_LOAD
    |=> !ctr_out_o[$past(idx)])
    else $error("mode 0 output not low");
  // reset clears outputs, checked even while reset is high
  reset_quiet_a: assert property (disable iff (1'b0) reset_i
    |=> ctr_out_o == '0 && !rd_valid_o && !ref_clk_o)
    else $error("outputs not cleared by reset");

  // main scenarios
  read_c: cover property (take && is_rd);
  m4_c: cover property (take && cmd_i.ctrl[3:1] == 3'h4);
  ref_c: cover property ($rose(ref_clk_o));
endmodule : interval_counter_bank_chk

bind interval_counter_bank interval_counter_bank_chk interval_counter_bank_chk_i (
  .clk_i, .reset_i, .ce_i, .cmd_valid_i, .cmd_i, .rd_valid_o, .rd_o,
  .ctr_out_o, .ref_clk_o);

`default_nettype wire

// >>> field_source.sv
// far side model: field clocks and gates wired to the counter pins
// assumes clk_i is the bank clock; pins idle high like pulled-up lines
`include "interval_counter_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module field_source #(
  parameter int HALF = 5
) (
  // bank clock and burst enable
  input wire logic clk_i,
  input wire logic run_i,
  // requested gate levels
  input wire logic [`NUM_CTRS-1:0] gate_req_i,
  // pins
  output logic [`NUM_CTRS-1:0] fclk_o,
  output logic [`NUM_CTRS-1:0] gate_o
);
  int cnt = 0;
  logic lvl = 1'b1;
  // wide field pulses
  // each phase lasts HALF cycles so the synchroniser never misses one
  always @(posedge clk_i) begin
    if (!run_i) begin
      cnt <= 0;
      lvl <= 1'b1;
    end else if (cnt == HALF - 1) begin
      cnt <= 0;
      lvl <= !lvl;
    end else begin
      cnt <= cnt + 1;
    end
  end
  assign fclk_o = {`NUM_CTRS{lvl}};
  assign gate_o = gate_req_i;
endmodule : field_source

`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the counter bank
// assumes the bank, its checker and the field source model
`include "interval_counter_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module tb_top;
  typedef struct {int g; int s; int m; int ld; int tr; int lo;} row_type;
  // group, sub, mode, load, trigger, low length (0: read check)
  row_type rows [8] = '{'{0, 1, 0, 'h1234, 0, 0}, '{4, 2, 0, 0, 0, 0},
    '{2, 1, 0, 'hffff, 0, 0}, '{0, 2, 1, 2, 1, 20}, '{1, 0, 2, 4, 0, 10},
    '{1, 1, 3, 5, 0, 20}, '{2, 0, 4, 3, 0, 10}, '{3, 0, 5, 3, 1, 10}};
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic ce_i = 1'b1;
  logic cmd_valid_i = 1'b0;
  interval_counter_pkg::cmd_type cmd_i = '0;
  logic rd_valid_o;
  interval_counter_pkg::rd_type rd_o;
  logic [`NUM_CTRS-1:0] fclk;
  logic [`NUM_CTRS-1:0] gate;
  logic [`NUM_CTRS-1:0] src = '0;
  logic [`NUM_CTRS-1:0] out;
  logic [`NUM_CTRS-1:0] gate_req = '1;
  logic ref_clk_o;
  logic run = 1'b0;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int len;
  int k;

  interval_counter_bank interval_counter_bank_i (.clk_i, .reset_i, .ce_i,
    .cmd_valid_i, .cmd_i, .rd_valid_o, .rd_o, .ctr_clk_i(fclk),
    .ctr_gate_i(gate), .ctr_src_ref_i(src), .ctr_out_o(out), .ref_clk_o);
  field_source field_source_i (.clk_i, .run_i(run), .gate_req_i(gate_req),
    .fclk_o(fclk), .gate_o(gate));

  // 4 ns clock
  always #2 clk_i = ~clk_i;

  // hang guard, well above the few thousand cycles needed
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      print_verdict();
    end
  end

  task automatic check(string what, logic [19:0] e, logic [19:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("[ERR] %s expected %0h seen %0h", what, e, g);
    end
  endtask : check

  // one command, held for exactly one edge
  task automatic send(logic [1:0] kd, int g, int s, int m, int ld);
    @(posedge clk_i);
    #1;
    cmd_i = '{kind: interval_counter_pkg::cmd_kind_type'(kd),
      group: 3'(g), ctrl: {2'(s), 2'h3, 3'(m), 1'b0}, load: 16'(ld)};
    cmd_valid_i = 1'b1;
    @(posedge clk_i);
    #1;
    cmd_valid_i = 1'b0;
  endtask : send

  // gate low pulse long enough to pass the synchroniser
  task automatic trig(int i);
    gate_req[i] = 1'b0;
    repeat (4) @(posedge clk_i);
    #1 gate_req[i] = 1'b1;
  endtask : trig

  // length of the next low phase, 0 when none comes
  task automatic low_len(int i, output int n);
    int w;
    w = 0;
    n = 0;
    while (out[i] !== 1'b0 && w < 600) begin
      @(posedge clk_i);
      #1 w++;
    end
    while (out[i] === 1'b0 && n < 600) begin
      @(posedge clk_i);
      #1 n++;
    end
  endtask : low_len

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (20) @(posedge clk_i);
    #1 reset_i = 1'b0;
    run = 1'b1;
    // ordinary cases: quiet mode 0 reads and one waveform for each of modes 1 to 5
    foreach (rows[r]) begin
      k = rows[r].g * 3 + rows[r].s;
      send(2'h2, rows[r].g, rows[r].s, rows[r].m, rows[r].ld);
      if (rows[r].lo == 0) begin
        repeat (50) @(posedge clk_i);
        send(2'h3, rows[r].g, rows[r].s, 0, 0);
        check("rd valid", 1, rd_valid_o);
        check("rd index", 20'(k), rd_o.index);
        check("rd count", 20'(rows[r].ld), rd_o.count);
        check("mode0 out", 0, out[k]);
      end else begin
        if (rows[r].tr != 0) trig(k);
        low_len(k, len);
        check("low len", 20'(rows[r].lo), 20'(len));
      end
    end
    // mode-only then load-only commands
    send(2'h0, 0, 1, 0, 0);
    send(2'h1, 0, 1, 0, 'h0042);
    send(2'h3, 0, 1, 0, 0);
    check("load only", 'h0042, rd_o.count);
    // retrigger inside the one-shot pulse stretches it
    send(2'h2, 0, 0, 1, 3);
    trig(0);
    fork
      low_len(0, len);
      begin
        wait (out[0] === 1'b0);
        repeat (15) @(posedge clk_i);
        #1 trig(0);
      end
    join
    check("retrigger", 1, len > 35 && len <= 70);
    // strobe on the internal reference, then silence
    src[5] = 1'b1;
    send(2'h2, 1, 2, 4, 2);
    low_len(5, len);
    check("ref strobe", 25, 20'(len));
    low_len(5, len);
    check("no restart", 0, 20'(len));
    // rate generator halts with its gate low
    gate_req[3] = 1'b0;
    repeat (5) @(posedge clk_i);
    #1 low_len(3, len);
    check("halt", 0, 20'(len));
    check("halt out", 1, out[3]);
    // mode 0 counts out after a trigger and then rises
    send(2'h2, 3, 1, 0, 2);
    trig(10);
    low_len(10, len);
    check("mode0 tc", 1, len > 12 && len < 26);
    send(2'h3, 3, 1, 0, 0);
    check("mode0 zero", 0, rd_o.count);
    // a low gate holds the strobe counter at its load
    gate_req[12] = 1'b0;
    repeat (5) @(posedge clk_i);
    send(2'h2, 4, 0, 4, 2);
    repeat (40) @(posedge clk_i);
    send(2'h3, 4, 0, 0, 0);
    check("m4 hold", 2, rd_o.count);
    check("m4 hold out", 1, out[12]);
    gate_req[12] = 1'b1;
    // refused and frozen reads
    send(2'h3, 5, 0, 0, 0);
    check("bad group", 0, rd_valid_o);
    ce_i = 1'b0;
    send(2'h3, 0, 1, 0, 0);
    check("ce low", 0, rd_valid_o);
    ce_i = 1'b1;
    // reset in mid-run
    reset_i = 1'b1;
    @(posedge clk_i);
    #1 check("reset out", 0, out);
    check("reset rd", 0, rd_valid_o);
    reset_i = 1'b0;
    print_verdict();
  end
endmodule : tb_top

`default_nettype wire
